// ===== ring_validation_timing.sv
// Ring validation timing with an AXI4-Lite register slave and interrupt.
`timescale 1ns/100ps

// Contract
// - Each crossing reloads interval timer, decrements per tick
// - Next crossing: timer above max limit means too fast
// - Too-fast ring is invalidated, restarts qualification
// - Assertion minus max limit sets minimum spacing
// - Six-bit max limit field bounds highest frequency
// - Delay code high bit sits in register B
// - Wait selected delay before indicating valid ring
// - Ring ends after timeout without crossing
// - Timeout code steps 128 ms; zero never used
// - Frequency in range for confirm time before valid
// - Confirm code selects 100 to 1024 ms
// - Register B resets to 0010_1101
// - Crossing after timer expiry means too slow
// - Enable bit gates validation in every power mode
// - Delay low bits sit at register A 7:6
module ring_validation_timing
   import ring_validation_pkg::*;
#(
   parameter int TICK_DIVIDE = TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ringCrossing,
   output logic ringValid,
   output logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------------------------------
   logic rstMeta;
   logic rstN;
   logic evtMeta;
   logic evtSync;
   logic evtLast;
   logic crossing;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         evtMeta <= 1'b0;
         evtSync <= 1'b0;
         evtLast <= 1'b0;
      end else begin
         evtMeta <= ringCrossing;
         evtSync <= evtMeta;
         evtLast <= evtSync;
      end
   end

   assign crossing = evtSync & ~evtLast;

   logic tick;

   tick_divider #(.DIVIDE(TICK_DIVIDE)) u_tick (
      .clk(ref_clk),
      .rstN(rstN),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] controlA;
   logic [7:0] controlB;
   logic [7:0] controlC;
   logic [STAT_W-1:0] status;
   logic [STAT_W-1:0] mask;
   logic [STAT_W-1:0] eventSet;

   logic [5:0] maxFreqLimit;
   logic [5:0] assertTime;
   logic [2:0] validIndicateDelay;
   logic [3:0] ringEndTimeout;
   logic [2:0] confirmTimeSel;
   logic validationEnable;

   assign maxFreqLimit = controlA[MAX_FREQ_MSB:0];
   assign validIndicateDelay = {controlB[DELAY_HIGH_BIT],
                                controlA[DELAY_LOW_MSB:DELAY_LOW_LSB]};
   assign ringEndTimeout = controlB[TIMEOUT_MSB:TIMEOUT_LSB];
   assign confirmTimeSel = controlB[CONFIRM_MSB:0];
   assign validationEnable = controlC[ENABLE_BIT];
   assign assertTime = controlC[ASSERT_MSB:0];

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [7:0] wIndex;
   logic [7:0] wByte;
   logic wByteEn;
   logic doWrite;
   logic wMapped;

   assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
   assign wMapped = (wIndex >= REG_CONTROL_A_IDX) && (wIndex <= REG_STATE_IDX);

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_awready <= 1'b0;
         awHeld <= 1'b0;
         wIndex <= '0;
      end else if (s_axi_awready && s_axi_awvalid) begin
         s_axi_awready <= 1'b0;
         awHeld <= 1'b1;
         wIndex <= s_axi_awaddr[9:2];
      end else begin
         if (doWrite) awHeld <= 1'b0;
         if (!awHeld && !s_axi_bvalid && !s_axi_awready) s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_wready <= 1'b0;
         wHeld <= 1'b0;
         wByte <= '0;
         wByteEn <= 1'b0;
      end else if (s_axi_wready && s_axi_wvalid) begin
         s_axi_wready <= 1'b0;
         wHeld <= 1'b1;
         wByte <= s_axi_wdata[7:0];
         wByteEn <= s_axi_wstrb[0];
      end else begin
         if (doWrite) wHeld <= 1'b0;
         if (!wHeld && !s_axi_bvalid && !s_axi_wready) s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         controlA <= CONTROL_A_RESET;
         controlB <= CONTROL_B_RESET;
         controlC <= CONTROL_C_RESET;
         mask <= '0;
      end else if (doWrite && wByteEn) begin
         case (wIndex)
            REG_CONTROL_A_IDX: controlA <= wByte;
            REG_CONTROL_B_IDX: controlB <= wByte;
            REG_CONTROL_C_IDX: controlC <= {wByte[7], 1'b0, wByte[5:0]};
            REG_MASK_IDX: mask <= wByte[STAT_W-1:0];
            default: ;
         endcase
      end
   end

   // Hardware set wins over a one-to-clear landing in the same cycle.
   logic [STAT_W-1:0] clearBits;

   assign clearBits = (doWrite && wByteEn && wIndex == REG_STATUS_IDX) ?
                      wByte[STAT_W-1:0] : '0;

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) status <= '0;
      else status <= (status & ~clearBits) | eventSet;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) irq <= 1'b0;
      else irq <= |(((status & ~clearBits) | eventSet) & mask);
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   ring_state_t state;
   logic [7:0] rIndex;
   logic [7:0] readByte;
   logic readMapped;

   assign rIndex = s_axi_araddr[9:2];

   always_comb begin
      readByte = '0;
      readMapped = 1'b1;
      case (rIndex)
         REG_CONTROL_A_IDX: readByte = controlA;
         REG_CONTROL_B_IDX: readByte = controlB;
         REG_CONTROL_C_IDX: readByte = controlC;
         REG_STATUS_IDX: readByte = {5'h00, status};
         REG_MASK_IDX: readByte = {5'h00, mask};
         REG_STATE_IDX: readByte = {5'h00, ringValid, state};
         default: readMapped = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, readByte};
         s_axi_rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
      end else begin
         if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
         if (!s_axi_rvalid && !s_axi_arready) s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Ring qualification
   // ----------------------------------------------------------------
   logic [5:0] intervalTimer;
   logic [TIME_CNT_W-1:0] confirmCount;
   logic [TIME_CNT_W-1:0] delayCount;
   logic [TIME_CNT_W-1:0] sinceCrossing;
   logic [TIME_CNT_W-1:0] confirmTicks;
   logic [TIME_CNT_W-1:0] delayTicks;
   logic [TIME_CNT_W-1:0] timeoutTicks;
   logic tooFast;
   logic tooSlow;
   logic ringOver;

   always_comb begin
      confirmTicks = '0;
      for (int i = 0; i < 8; i++) begin
         if (confirmTimeSel == 3'(i)) confirmTicks = TIME_CNT_W'(CONFIRM_MS[i] * 1000 / TICK_US);
      end
   end

   // Codes between the listed delays follow the same 256 ms step.
   assign delayTicks = TIME_CNT_W'(validIndicateDelay * DELAY_STEP_TICKS);
   // Code zero is forbidden; it is held at the first step rather than an instant end.
   assign timeoutTicks = TIME_CNT_W'(((ringEndTimeout == 4'h0) ? 4'h1 : ringEndTimeout)
                                     * TIMEOUT_STEP_TICKS);

   // The window between the two limits is the accepted spacing.
   assign tooFast = intervalTimer > maxFreqLimit;
   assign tooSlow = intervalTimer == 6'h00;
   assign ringOver = (state != ST_IDLE) && !crossing && (sinceCrossing >= timeoutTicks);

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) intervalTimer <= '0;
      else if (crossing) intervalTimer <= assertTime;
      else if (tick && intervalTimer != 6'h00) intervalTimer <= intervalTimer - 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) sinceCrossing <= '0;
      else if (crossing || state == ST_IDLE) sinceCrossing <= '0;
      else if (tick && sinceCrossing != '1) sinceCrossing <= sinceCrossing + 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         state <= ST_IDLE;
         confirmCount <= '0;
         delayCount <= '0;
         ringValid <= 1'b0;
         eventSet <= '0;
      end else begin
         eventSet <= '0;
         if (!validationEnable) begin
            state <= ST_IDLE;
            ringValid <= 1'b0;
         end else if (ringOver) begin
            state <= ST_IDLE;
            ringValid <= 1'b0;
            eventSet[STAT_END_BIT] <= 1'b1;
         end else begin
            case (state)
               ST_IDLE: begin
                  confirmCount <= '0;
                  if (crossing) state <= ST_QUAL;
               end
               ST_QUAL: begin
                  if (crossing && (tooFast || tooSlow)) begin
                     confirmCount <= '0;
                     eventSet[STAT_INVALID_BIT] <= 1'b1;
                  end else if (confirmCount >= confirmTicks) begin
                     delayCount <= '0;
                     state <= ST_DELAY;
                  end else if (tick) begin
                     confirmCount <= confirmCount + 1'b1;
                  end
               end
               ST_DELAY: begin
                  if (delayCount >= delayTicks) begin
                     state <= ST_VALID;
                     ringValid <= 1'b1;
                     eventSet[STAT_VALID_BIT] <= 1'b1;
                  end else if (tick) begin
                     delayCount <= delayCount + 1'b1;
                  end
               end
               ST_VALID: ringValid <= 1'b1;
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

endmodule : ring_validation_timing

// ===== ring_validation_pkg.sv
// Shared constants for the ring validation timing block.
package ring_validation_pkg;

   // ----------------------------------------------------------------
   // Clock and timebase
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_US = 2000;
   localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 17;

   // ----------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CONTROL_A_IDX = 8'h16;
   localparam logic [7:0] REG_CONTROL_B_IDX = 8'h17;
   localparam logic [7:0] REG_CONTROL_C_IDX = 8'h18;
   localparam logic [7:0] REG_STATUS_IDX = 8'h19;
   localparam logic [7:0] REG_MASK_IDX = 8'h1a;
   localparam logic [7:0] REG_STATE_IDX = 8'h1b;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CONTROL_A_RESET = 8'h96;
   localparam logic [7:0] CONTROL_B_RESET = 8'h2d;
   localparam logic [7:0] CONTROL_C_RESET = 8'h19;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DELAY_LOW_MSB = 7;
   localparam int DELAY_LOW_LSB = 6;
   localparam int MAX_FREQ_MSB = 5;
   localparam int DELAY_HIGH_BIT = 7;
   localparam int TIMEOUT_MSB = 6;
   localparam int TIMEOUT_LSB = 3;
   localparam int CONFIRM_MSB = 2;
   localparam int ENABLE_BIT = 7;
   localparam int ASSERT_MSB = 5;
   localparam int STAT_VALID_BIT = 0;
   localparam int STAT_END_BIT = 1;
   localparam int STAT_INVALID_BIT = 2;
   localparam int STAT_W = 3;

   // ----------------------------------------------------------------
   // Times in ms and their counts of timebase ticks
   // ----------------------------------------------------------------
   localparam int DELAY_STEP_MS = 256;
   localparam int TIMEOUT_STEP_MS = 128;
   localparam int CONFIRM_MS [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};
   localparam int DELAY_STEP_TICKS = DELAY_STEP_MS * 1000 / TICK_US;
   localparam int TIMEOUT_STEP_TICKS = TIMEOUT_STEP_MS * 1000 / TICK_US;
   localparam int TIME_CNT_W = 10;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_QUAL = 2'b01,
      ST_DELAY = 2'b11,
      ST_VALID = 2'b10
   } ring_state_t;

endpackage : ring_validation_pkg

// ===== tick_divider.sv
// Free-running divider that makes the slow timebase tick.
`timescale 1ns/100ps
module tick_divider
   import ring_validation_pkg::*;
#(
   parameter int DIVIDE = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rstN,
   output logic tick
);

   logic [TICK_CNT_W-1:0] count;

   // The count restarts at zero so every tick is exactly DIVIDE cycles apart.
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count <= '0;
         tick <= 1'b0;
      end else if (count == TICK_CNT_W'(DIVIDE - 1)) begin
         count <= '0;
         tick <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick <= 1'b0;
      end
   end

endmodule : tick_divider

// ===== ring_validation_timing_assertions.sv
// Concurrent checks on the ports of the ring validation timing block.
`timescale 1ns/100ps
module ring_validation_timing_assertions
   import ring_validation_pkg::*;
#(
   parameter int TICK_DIVIDE = TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ringCrossing,
   input wire logic ringValid,
   input wire logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // --------------------------------
   // Helper counters
   // --------------------------------
   logic [31:0] sinceCross;
   logic [31:0] runCnt;
   logic wrTaken;
   logic [7:0] awIdx;
   logic [7:0] arIdx;
   assign wrTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign awIdx = s_axi_awaddr[9:2];
   assign arIdx = s_axi_araddr[9:2];
   // A burst only counts while the gaps stay shorter than the shortest timeout.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sinceCross <= 32'h0010_0000;
         runCnt <= 32'h0;
      end else begin
         sinceCross <= ringCrossing ? 32'h0 : sinceCross + 32'h1;
         runCnt <= (sinceCross > 64 * TICK_DIVIDE) ? 32'h0 : runCnt + 32'h1;
      end
   end
   // --------------------------------
   // Assertions
   // --------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read response changed early");
   a_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_unmapped_write: assert property (wrTaken && (awIdx < REG_CONTROL_A_IDX
      || awIdx > REG_STATE_IDX) |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && (arIdx <
      REG_CONTROL_A_IDX || arIdx > REG_STATE_IDX) |=> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_ring_end_bound: assert property (ringValid |-> sinceCross <= 962 * TICK_DIVIDE)
      else $error("valid ring outlived the longest timeout");
   a_confirm_first: assert property ($rose(ringValid) |-> runCnt >= 48 * TICK_DIVIDE)
      else $error("valid ring before shortest confirmation");
   c_valid: cover property ($rose(ringValid));
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : ring_validation_timing_assertions

bind ring_validation_timing ring_validation_timing_assertions #(.TICK_DIVIDE(TICK_DIVIDE)) chk (
   .ref_clk, .reset_n, .ringCrossing, .ringValid, .irq, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// ===== ring_crossing_source.sv
// Behavioural line-side detector that emits crossings at a chosen spacing.
`timescale 1ns/100ps
module ring_crossing_source (
   input wire logic clk,
   input wire logic run,
   input wire logic [15:0] period,
   output logic ringCrossing = 1'b0
);
   logic [15:0] phase = 16'h0;
   // Pulse and gap are half the spacing each, so both last at least two clocks from 4 up.
   always @(posedge clk) begin
      if (!run) begin
         phase <= 16'h0;
         ringCrossing <= 1'b0;
      end else begin
         phase <= (phase + 16'h1 == period) ? 16'h0 : phase + 16'h1;
         ringCrossing <= phase < (period >> 1);
      end
   end
endmodule : ring_crossing_source

// ===== ring_validation_timing_test.sv
// Self-checking test of the ring validation timing block.
`timescale 1ns/100ps
module ring_validation_timing_test;
   import ring_validation_pkg::*;
   localparam int TD = 10;
   logic ref_clk, reset_n = 1'b0, run = 1'b0, prevCross = 1'b0, ringCrossing, ringValid, irq;
   logic [15:0] period = 16'd100;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int n_errors = 0, comparisons = 0, sinceRise = 0, t, e;
   int per[8] = '{100, 40, 240, 100, 60, 100, 100, 100};
   logic [2:0] dl[8] = '{0, 1, 2, 7, 3, 0, 1, 6};
   logic [3:0] to[8] = '{1, 2, 15, 3, 1, 2, 4, 1};
   ring_validation_timing #(.TICK_DIVIDE(TD)) dut (
      .ref_clk, .reset_n, .ringCrossing, .ringValid, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   ring_crossing_source source (.clk(ref_clk), .run, .period, .ringCrossing);
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      prevCross <= ringCrossing;
      sinceRise <= (ringCrossing && !prevCross) ? 0 : sinceRise + 1;
   end
   // --------------------------------
   // Checks and bus tasks
   // --------------------------------
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", n, x, g);
      end
   endtask : chk
   task automatic win(input string n, input int lo, input int hi, input int g);
      comparisons++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("unexpected %s: expected %0d to %0d, seen %0d", n, lo, hi, g);
      end
   endtask : win
   // Bus waits have no limit of their own; a hung slave is caught by the watchdog.
   task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
      @(posedge ref_clk);
      s_axi_awaddr <= {22'h0, i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("write resp", {29'h0, 1'b1, er}, {29'h0, s_axi_bvalid, s_axi_bresp});
   endtask : wr
   task automatic rd(input logic [7:0] i, input logic [7:0] x, input logic [1:0] er);
      @(posedge ref_clk);
      s_axi_araddr <= {22'h0, i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("read resp", {29'h0, 1'b1, er}, {29'h0, s_axi_rvalid, s_axi_rresp});
      chk("read data", {24'h0, x}, s_axi_rdata);
   endtask : rd
   task automatic waitLvl(input logic lvl, input int lim);
      t = 0;
      while (ringValid !== lvl && t < lim) begin
         @(posedge ref_clk);
         t++;
      end
      chk("ring valid", {31'h0, lvl}, {31'h0, ringValid});
   endtask : waitLvl
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   // --------------------------------
   // Scenarios
   // --------------------------------
   initial begin
      // The scenarios need about 70,000 cycles; this leaves a margin.
      repeat (90000) @(posedge ref_clk);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(REG_CONTROL_A_IDX, 8'h96, RESP_OKAY);
      rd(REG_CONTROL_B_IDX, 8'h2d, RESP_OKAY);
      rd(REG_CONTROL_C_IDX, 8'h19, RESP_OKAY);
      rd(8'h30, 8'h00, RESP_SLVERR);
      wr(8'h30, 8'hff, RESP_SLVERR);
      wr(REG_CONTROL_C_IDX, 8'hff, RESP_OKAY);
      rd(REG_CONTROL_C_IDX, 8'hbf, RESP_OKAY);
      // A write without its low byte lane must leave the register alone.
      s_axi_wstrb <= 4'he;
      wr(REG_CONTROL_C_IDX, 8'h00, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(REG_CONTROL_C_IDX, 8'hbf, RESP_OKAY);
      wr(REG_CONTROL_B_IDX, 8'h08, RESP_OKAY);
      wr(REG_CONTROL_A_IDX, 8'h16, RESP_OKAY);
      wr(REG_CONTROL_C_IDX, 8'h19, RESP_OKAY);
      run <= 1'b1;
      repeat (1000) @(posedge ref_clk);
      chk("ring valid off", 32'h0, {31'h0, ringValid});
      rd(REG_STATUS_IDX, 8'h00, RESP_OKAY);
      run <= 1'b0;
      wr(REG_CONTROL_C_IDX, 8'h99, RESP_OKAY);
      for (int p = 0; p < 2; p++) begin
         wr(REG_MASK_IDX, 8'h00, RESP_OKAY);
         period <= p ? 16'd300 : 16'd20;
         run <= 1'b1;
         repeat (2000) @(posedge ref_clk);
         chk("ring valid bad rate", 32'h0, {31'h0, ringValid});
         rd(REG_STATUS_IDX, 8'h04, RESP_OKAY);
         chk("irq masked", 32'h0, {31'h0, irq});
         wr(REG_MASK_IDX, 8'h07, RESP_OKAY);
         @(posedge ref_clk);
         chk("irq", 32'h1, {31'h0, irq});
         run <= 1'b0;
         repeat (1000) @(posedge ref_clk);
         wr(REG_STATUS_IDX, 8'h07, RESP_OKAY);
      end
      for (int i = 0; i < 8; i++) begin
         e = CONFIRM_MS[i] * 1000 / TICK_US + dl[i] * DELAY_STEP_TICKS;
         wr(REG_CONTROL_A_IDX, {dl[i][1:0], 6'd22}, RESP_OKAY);
         wr(REG_CONTROL_B_IDX, {dl[i][2], to[i], 3'(i)}, RESP_OKAY);
         period <= per[i][15:0];
         run <= 1'b1;
         waitLvl(1'b1, 15000);
         win("ring valid time", (e - 2) * TD, (e + 2) * TD + 20, t);
         rd(REG_STATUS_IDX, 8'h01, RESP_OKAY);
         rd(REG_STATE_IDX, 8'h06, RESP_OKAY);
         chk("irq", 32'h1, {31'h0, irq});
         run <= 1'b0;
         waitLvl(1'b0, 12000);
         e = to[i] * TIMEOUT_STEP_TICKS;
         win("ring end time", (e - 1) * TD, (e + 2) * TD + 10, sinceRise);
         rd(REG_STATUS_IDX, 8'h03, RESP_OKAY);
         wr(REG_STATUS_IDX, 8'h07, RESP_OKAY);
         @(posedge ref_clk);
         chk("irq cleared", 32'h0, {31'h0, irq});
      end
      conclude();
   end
endmodule : ring_validation_timing_test
